/* rtl/emg_defs.vh */
// Constants for the receive mask and transmit gap block.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef EMG_DEFS_VH
`define EMG_DEFS_VH
`define EMG_OFS_MASK_LO 8'h00
`define EMG_OFS_MASK_HI 8'h10
`define EMG_OFS_GAP 8'h20
`define EMG_OFS_CTRL 8'h30
`define EMG_OFS_STAT 8'h40
`define EMG_ALIAS_CLR 2'h1
`define EMG_ALIAS_SET 2'h2
`define EMG_ALIAS_INV 2'h3
`define EMG_GAP_W 7
`define EMG_GAP_RST 7'h12
`define EMG_MASK_RST 32'h0000_0000
`define EMG_CTRL_RECEIVE_ENABLE_BIT_BIT 0
`define EMG_CTRL_PMSEL_LSB 8
`define EMG_CTRL_PMSEL_MSB 11
`define EMG_CTRL_FDX_BIT 16
`define EMG_NIB_CYC 2
`endif

/* rtl/emg_fifo.v */
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module emg_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire mclk,
	input wire rst,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_ff;
	reg [AW-1:0] rd_ptr_ff;
	reg [AW:0] count_ff;
	reg ready_ff;
	wire push;
	wire pop;
	wire [AW:0] nxt_count;

	// Ready is a flop loaded from the next occupancy; empty comes from the count.
	assign in_ready = ready_ff;
	assign out_valid = (count_ff != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_ff];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign nxt_count = (push && !pop) ? count_ff + 1'b1
		: ((pop && !push) ? count_ff - 1'b1 : count_ff);

	// Storage is written without reset; only the pointers, count and ready need a defined value.
	always @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

	// Pointers wrap at DEPTH, which must be a power of two.
	always @(posedge mclk) begin
		if (rst) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff <= {(AW+1){1'b0}};
			ready_ff <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			count_ff <= nxt_count;
			ready_ff <= (nxt_count != DEPTH[AW:0]);
		end
	end
endmodule // emg_fifo

/* rtl/emg_top.v */
// Receive pattern mask registers, transmit back-to-back gap and its bus slave.
// Assumes an Avalon-MM master on mclk, a transmit byte stream from the MAC
// core and a receive byte window from the receive filter.
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "emg_defs.vh"

// Notes on behaviour
// [R1] Mask of 64 bits over two registers; byte 0 low, byte 7 at top.
// [R2] Mask steers receive matching only; transmit never looks at it.
// [R3] Software changes the mask only when receive is off or matching off.
// [R4] Gap field is seven bits, resets to 0x12, upper bits read zero.
// [R5] Each packet start waits at least the programmed gap in nibble times.
// [R6] Software programs the wanted gap minus 3 full duplex, minus 6 half.
// [R7] Recommended settings are 0x15 full duplex and 0x12 half duplex.
// [R8] Sixteen and 32-bit accesses work, aliases too; byte accesses are ignored.
// [R9] Clear, set and invert aliases sit at plus 0x4, 0x8 and 0xC.
// [R10] Mask bit 8n lets byte n of the window take part in matching.
module emg_top #(
	parameter NIB_CYC = `EMG_NIB_CYC
) (
	input wire mclk,
	input wire rst,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire [7:0] tx_in_data,
	input wire tx_in_last,
	input wire tx_in_valid,
	output wire tx_in_ready,
	output reg [3:0] tx_nibble,
	output reg tx_en,
	input wire [63:0] rx_window,
	input wire [63:0] rx_pattern,
	input wire rx_window_valid,
	output reg rx_match,
	output reg rx_match_valid,
	output reg receive_enable_bit,
	output reg [3:0] pattern_match_select
);
	reg [31:0] mask_lo_ff;
	reg [31:0] mask_hi_ff;
	reg [6:0] gap_ff;
	reg [31:0] ctrl_ff;
	reg done_ff;
	reg [31:0] nxt_reg;
	reg [31:0] old_val;
	reg [31:0] rd_val;
	reg hit;
	wire [63:0] pattern_mask;
	wire [1:0] alias_sel;
	wire [7:0] base_addr;
	wire size_ok;
	wire wr_go;

	// Byte enable decode shared by read and write; one lane alone is a byte access.
	function lanes_ok;
		input [3:0] be;
		begin
			lanes_ok = (be == 4'b1111) || (be == 4'b0011) || (be == 4'b1100);
		end
	endfunction

	// Expand byte enables to a bit mask so a 16-bit write touches only its half.
	function [31:0] lane_bits;
		input [3:0] be;
		begin
			lane_bits = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		end
	endfunction

	assign pattern_mask = {mask_hi_ff, mask_lo_ff}; // [R1]
	assign alias_sel = avs_address[3:2]; // [R9]
	assign base_addr = {avs_address[7:4], 4'h0};
	assign size_ok = lanes_ok(avs_byteenable); // [R8]
	assign wr_go = avs_write && done_ff && size_ok; // [R8]

	// Select the current value of the addressed register.
	always @* begin
		hit = 1'b1;
		old_val = 32'h0000_0000;
		case (base_addr)
			`EMG_OFS_MASK_LO: old_val = mask_lo_ff;
			`EMG_OFS_MASK_HI: old_val = mask_hi_ff;
			`EMG_OFS_GAP: old_val = {25'h000_0000, gap_ff}; // [R4]
			`EMG_OFS_CTRL: old_val = ctrl_ff;
			`EMG_OFS_STAT: old_val = {30'h0000_0000, tx_en, rx_match};
			default: hit = 1'b0;
		endcase
	end

	// Read data: aliases read the base register; byte reads give zero.
	always @* begin
		rd_val = 32'h0000_0000;
		if (hit && size_ok) begin
			rd_val = old_val; // [R8]
		end
	end

	// Compute the written value through the plain, clear, set or invert alias.
	always @* begin
		case (alias_sel)
			`EMG_ALIAS_CLR: nxt_reg = old_val & ~(avs_writedata & lane_bits(avs_byteenable));
			`EMG_ALIAS_SET: nxt_reg = old_val | (avs_writedata & lane_bits(avs_byteenable));
			`EMG_ALIAS_INV: nxt_reg = old_val ^ (avs_writedata & lane_bits(avs_byteenable));
			default: nxt_reg = (old_val & ~lane_bits(avs_byteenable))
				| (avs_writedata & lane_bits(avs_byteenable));
		endcase
	end

	// Every access answers after one wait cycle; done_ff marks the answer edge.
	always @(posedge mclk) begin
		if (rst) begin
			done_ff <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			done_ff <= (avs_read || avs_write) && !done_ff;
			avs_waitrequest <= !((avs_read || avs_write) && !done_ff);
			if (avs_read && !done_ff) begin
				avs_readdata <= rd_val;
			end
		end
	end

	// Register writes land at the answer edge; byte and unmapped writes change nothing.
	always @(posedge mclk) begin
		if (rst) begin
			mask_lo_ff <= `EMG_MASK_RST;
			mask_hi_ff <= `EMG_MASK_RST;
			gap_ff <= `EMG_GAP_RST; // [R4]
			ctrl_ff <= 32'h0000_0000;
		end else if (wr_go) begin // [R8]
			case (base_addr)
				`EMG_OFS_MASK_LO: mask_lo_ff <= nxt_reg; // [R9]
				`EMG_OFS_MASK_HI: mask_hi_ff <= nxt_reg; // [R9]
				`EMG_OFS_GAP: gap_ff <= nxt_reg[6:0]; // [R4]
				`EMG_OFS_CTRL: ctrl_ff <= nxt_reg;
				default: ctrl_ff <= ctrl_ff;
			endcase
		end
	end

	// Control bits leave the block as registered levels.
	always @(posedge mclk) begin
		if (rst) begin
			receive_enable_bit <= 1'b0;
			pattern_match_select <= 4'h0;
		end else begin
			receive_enable_bit <= ctrl_ff[`EMG_CTRL_RECEIVE_ENABLE_BIT_BIT];
			pattern_match_select <= ctrl_ff[`EMG_CTRL_PMSEL_MSB:`EMG_CTRL_PMSEL_LSB];
		end
	end

	// Receive match: masked bytes compare window against pattern.
	reg all_eq;
	integer i;
	always @* begin
		all_eq = 1'b1;
		for (i = 0; i < 8; i = i + 1) begin
			if (pattern_mask[i*8] && (rx_window[i*8 +: 8] != rx_pattern[i*8 +: 8])) begin
				all_eq = 1'b0; // [R10]
			end
		end
	end

	// Results are flagged valid only while receive is on and a match mode is chosen.
	always @(posedge mclk) begin
		if (rst) begin
			rx_match <= 1'b0;
			rx_match_valid <= 1'b0;
		end else begin
			rx_match_valid <= rx_window_valid && receive_enable_bit
				&& (pattern_match_select != 4'h0);
			if (rx_window_valid) begin
				rx_match <= all_eq; // [R2]
			end
		end
	end

	// Transmit path: FIFO of 4 bytes with a last flag feeds the nibble sender.
	wire [8:0] fifo_data;
	wire fifo_valid;
	reg fifo_pop;
	emg_fifo #(
		.WIDTH(9),
		.DEPTH(4),
		.AW(2)
	) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_data({tx_in_last, tx_in_data}),
		.in_valid(tx_in_valid),
		.in_ready(tx_in_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	localparam ST_GAP = 2'd0;
	localparam ST_IDLE = 2'd1;
	localparam ST_LO = 2'd2;
	localparam ST_HI = 2'd3;
	reg [1:0] st_ff;
	reg [1:0] nxt_st;
	reg [7:0] nib_cnt_ff;
	reg [7:0] cyc_cnt_ff;
	reg [7:0] gap_goal;
	reg last_ff;
	wire nib_tick;

	// The gap is taken from the register alone; the mask plays no part.
	always @* begin
		gap_goal = {1'b0, gap_ff}; // [R2]
	end

	assign nib_tick = (cyc_cnt_ff == NIB_CYC[7:0] - 8'd1);

	// Cycle divider producing one tick per nibble time.
	always @(posedge mclk) begin
		if (rst || nib_tick) begin
			cyc_cnt_ff <= 8'h00;
		end else begin
			cyc_cnt_ff <= cyc_cnt_ff + 8'd1;
		end
	end

	// Next state: start only after the gap has run, send low nibble first.
	always @* begin
		nxt_st = st_ff;
		fifo_pop = 1'b0;
		case (st_ff)
			ST_GAP: begin
				if (nib_tick && nib_cnt_ff >= gap_goal) begin
					nxt_st = ST_IDLE; // [R5]
				end
			end
			ST_IDLE: begin
				if (nib_tick && fifo_valid) begin
					nxt_st = ST_LO;
				end
			end
			ST_LO: begin
				// The byte leaves the buffer as its high nibble is loaded, so the
				// buffer head is already the next byte when the high nibble ends.
				if (nib_tick) begin
					fifo_pop = 1'b1;
					nxt_st = ST_HI;
				end
			end
			ST_HI: begin
				// An empty buffer in mid-packet cuts the frame rather than repeat data.
				if (nib_tick) begin
					if (last_ff || !fifo_valid) begin
						nxt_st = ST_GAP; // [R5]
					end else begin
						nxt_st = ST_LO;
					end
				end
			end
			default: nxt_st = ST_GAP;
		endcase
	end

	// Transmit state, nibble output and gap counter.
	always @(posedge mclk) begin
		if (rst) begin
			st_ff <= ST_GAP;
			nib_cnt_ff <= 8'h00;
			last_ff <= 1'b0;
			tx_en <= 1'b0;
			tx_nibble <= 4'h0;
		end else begin
			st_ff <= nxt_st;
			if (st_ff != ST_GAP) begin
				nib_cnt_ff <= 8'h00;
			end else if (nib_tick && nib_cnt_ff != 8'hff) begin
				nib_cnt_ff <= nib_cnt_ff + 8'd1; // [R5]
			end
			tx_en <= (nxt_st == ST_LO) || (nxt_st == ST_HI);
			// The last flag of the byte being sent is kept once it leaves the buffer.
			if (fifo_pop) begin
				last_ff <= fifo_data[8];
			end
			// A nibble loads only on a change of state, so it holds for a whole
			// nibble time even though the buffer head moves on meanwhile.
			if (nxt_st != st_ff) begin
				if (nxt_st == ST_LO) begin
					tx_nibble <= fifo_data[3:0];
				end else if (nxt_st == ST_HI) begin
					tx_nibble <= fifo_data[7:4];
				end else begin
					tx_nibble <= 4'h0;
				end
			end
		end
	end
endmodule // emg_top

/* verification/emg_top_props.sv */
// Checker for the mask and gap block, attached to emg_top by bind.
// Assumes the Avalon-MM master and the stream ports all run on mclk.
`timescale 1ns/100ps
module emg_top_chk (
	input wire mclk,
	input wire rst,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire tx_en,
	input wire rx_window_valid,
	input wire receive_enable_bit,
	input wire [3:0] pattern_match_select,
	input wire rx_match_valid
);
	// Request and lane qualifiers shared by the properties.
	wire req = avs_read || avs_write;
	wire rd_done = avs_read && !avs_waitrequest;
	wire lanes_ok = avs_byteenable == 4'hf || avs_byteenable == 4'h3 || avs_byteenable == 4'hc;
	wire match_on = rx_window_valid && receive_enable_bit && pattern_match_select != 4'h0;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Bus answer timing, read values and match timing.
	a_wait_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer after one wait cycle");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_wait_idle: assert property (!req && avs_waitrequest |=> avs_waitrequest)
		else $error("answer without a request");
	a_gap_upper: assert property (rd_done && avs_address[7:4] == 4'h2 |-> avs_readdata[31:7] == 25'h0)
		else $error("gap upper bits not zero");
	a_byte_ignored: assert property (rd_done && !lanes_ok |-> avs_readdata == 32'h0000_0000)
		else $error("byte read returned data");
	a_match_follow: assert property (match_on |=> rx_match_valid)
		else $error("match result missing");
	a_match_pulse: assert property (!match_on |=> !rx_match_valid)
		else $error("match result without window");
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> avs_waitrequest && !tx_en)
		else $error("outputs active in reset");
	// Main scenarios.
	c_gap_read: cover property (rd_done && avs_address[7:4] == 4'h2);
	c_match: cover property (rx_match_valid);
	c_tx: cover property ($rose(tx_en));
endmodule // emg_top_chk

bind emg_top emg_top_chk u_chk (.mclk(mclk), .rst(rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_en(tx_en),
	.rx_window_valid(rx_window_valid), .receive_enable_bit(receive_enable_bit),
	.pattern_match_select(pattern_match_select), .rx_match_valid(rx_match_valid));

/* verification/emg_phy_model.sv */
// Link partner model that receives the transmit nibble stream.
// Assumes one nibble per cycle, low nibble first, framed by tx_en.
`timescale 1ns/100ps
module emg_phy_model (
	input wire mclk,
	input wire rst,
	input wire tx_en,
	input wire [3:0] tx_nibble,
	output logic [7:0] last_byte,
	output int n_bytes,
	output int min_gap
);
	logic half;
	logic [3:0] lo;
	logic seen;
	int idle;
	// Rebuild bytes and keep the shortest idle run between frames.
	always @(posedge mclk) begin
		if (rst) begin
			half <= 0;
			seen <= 0;
			idle <= 0;
			n_bytes <= 0;
			min_gap <= 9999;
		end else if (tx_en) begin
			if (seen && idle != 0 && idle < min_gap)
				min_gap <= idle;
			idle <= 0;
			seen <= 1;
			half <= !half;
			if (!half)
				lo <= tx_nibble;
			else begin
				last_byte <= {tx_nibble, lo};
				n_bytes <= n_bytes + 1;
			end
		end else begin
			half <= 0;
			idle <= idle + 1;
		end
	end
endmodule // emg_phy_model

/* verification/tb_top.sv */
// Self-checking bench for emg_top with a link partner model.
// Assumes the design files under rtl/ and the checker are compiled first.
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
	typedef struct {logic [7:0] a; logic [3:0] be; logic [31:0] d; logic [31:0] exp;} emg_row_t;
	localparam int GAP = 8 - 3;
	logic mclk, rst, avs_read, avs_write, tx_in_last, tx_in_valid, rx_window_valid;
	logic [7:0] avs_address, tx_in_data, last_byte;
	logic [31:0] avs_writedata, q;
	logic [3:0] avs_byteenable;
	logic [63:0] rx_pattern, rx_window;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, tx_in_ready, tx_en, rx_match, rx_match_valid, receive_enable_bit;
	wire [3:0] tx_nibble, pattern_match_select;
	int n_mismatch = 0, total_checks = 0, cyc = 0, n_refuse = 0, n_bytes, min_gap;
	// Write through an alias, then read the base register back.
	emg_row_t rows [12] = '{
		'{8'h00, 4'hf, 32'h1234_5678, 32'h1234_5678}, '{8'h04, 4'hf, 32'h0000_00ff, 32'h1234_5600},
		'{8'h08, 4'hf, 32'h0000_000f, 32'h1234_560f}, '{8'h0c, 4'hf, 32'hffff_0000, 32'hedcb_560f},
		'{8'h00, 4'h1, 32'h0000_0000, 32'hedcb_560f}, '{8'h00, 4'h3, 32'h0000_aaaa, 32'hedcb_aaaa},
		'{8'h0c, 4'hc, 32'hffff_0000, 32'h1234_aaaa}, '{8'h10, 4'hf, 32'hff00_0001, 32'hff00_0001},
		'{8'h18, 4'h3, 32'h0000_0f00, 32'hff00_0f01}, '{8'h20, 4'hf, 32'hffff_ffff, 32'h0000_007f},
		'{8'h24, 4'hf, 32'h0000_0070, 32'h0000_000f}, '{8'h20, 4'hf, 32'h0000_0015, 32'h0000_0015}};

	emg_top #(.NIB_CYC(1)) u_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tx_in_data(tx_in_data), .tx_in_last(tx_in_last),
		.tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_nibble(tx_nibble), .tx_en(tx_en),
		.rx_window(rx_window), .rx_pattern(rx_pattern),
		.rx_window_valid(rx_window_valid), .rx_match(rx_match), .rx_match_valid(rx_match_valid),
		.receive_enable_bit(receive_enable_bit), .pattern_match_select(pattern_match_select));
	emg_phy_model u_phy (.mclk(mclk), .rst(rst), .tx_en(tx_en), .tx_nibble(tx_nibble),
		.last_byte(last_byte), .n_bytes(n_bytes), .min_gap(min_gap));

	// Clock and hang guard.
	initial begin
		mclk = 0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			wrap_up;
		end
	end

	// One bus access, held until waitrequest is seen low at a rising edge.
	task bus(input logic rd, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge mclk);
		avs_read <= rd;
		avs_write <= !rd;
		avs_address <= a;
		avs_byteenable <= be;
		avs_writedata <= d;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
	endtask

	// One packet pushed back to back, counting cycles the buffer refuses.
	task send_pkt(input int n, input logic [7:0] b0);
		@(posedge mclk);
		for (int i = 0; i < n; i++) begin
			tx_in_data <= b0 + 8'(i);
			tx_in_last <= (i == n - 1);
			tx_in_valid <= 1;
			@(posedge mclk);
			while (tx_in_ready !== 1'b1) begin
				n_refuse++;
				@(posedge mclk);
			end
		end
		tx_in_valid <= 0;
	endtask

	// One window compared against a pattern, result checked a cycle later.
	task rx_try(input logic [63:0] win, input logic [63:0] pat, input logic exp);
		@(posedge mclk);
		rx_window <= win;
		rx_pattern <= pat;
		rx_window_valid <= 1;
		@(posedge mclk);
		rx_window_valid <= 0;
		@(posedge mclk);
		`CHK({rx_match_valid, rx_match}, {1'b1, exp})
	endtask

	// Prints the counts and the verdict, then stops.
	task wrap_up;
		$display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Main sequence.
	initial begin
		{rst, avs_read, avs_write, tx_in_last, tx_in_valid, rx_window_valid} = 6'h20;
		{avs_address, avs_byteenable, avs_writedata, tx_in_data, rx_pattern, rx_window} = '0;
		repeat (8) @(posedge mclk);
		rst <= 0;
		foreach (rows[i]) begin
			bus(0, rows[i].a, rows[i].be, rows[i].d); // receive stays off
			bus(1, {rows[i].a[7:4], 4'h0}, 4'hf, 32'h0000_0000);
			`CHK(q, rows[i].exp)
		end
		bus(0, 8'h50, 4'hf, 32'hffff_ffff);
		bus(1, 8'h50, 4'hf, 32'h0000_0000);
		`CHK(q, 32'h0000_0000)
		bus(1, 8'h00, 4'h1, 32'h0000_0000);
		`CHK(q, 32'h0000_0000)
		@(posedge mclk);
		rst <= 1;
		repeat (2) @(posedge mclk);
		rst <= 0;
		for (int k = 0; k < 3; k++) begin
			bus(1, 8'(k * 16), 4'hf, 32'h0000_0000);
			`CHK(q, (k == 2) ? 32'h0000_0012 : 32'h0000_0000)
		end
		bus(0, 8'h00, 4'hf, 32'h0000_0100); // mask set while receive is off
		bus(0, 8'h30, 4'hf, 32'h0000_0101);
		repeat (2) @(posedge mclk);
		`CHK({receive_enable_bit, pattern_match_select}, 5'h11)
		rx_try(64'h0000_0000_0000_0000, 64'h0000_0000_0000_00ff, 1'b1);
		rx_try(64'h0000_0000_0000_0000, 64'h0000_0000_0000_ff00, 1'b0);
		rx_try(64'h0000_0000_00ab_1200, 64'h0000_0000_0000_12ff, 1'b1);
		bus(1, 8'h40, 4'hf, 32'h0000_0000);
		`CHK(q, 32'h0000_0001)
		bus(0, 8'h20, 4'hf, 32'(GAP));
		send_pkt(6, 8'h10);
		send_pkt(2, 8'ha5);
		wait (n_bytes == 8);
		repeat (4) @(posedge mclk);
		`CHK(last_byte, 8'ha6)
		`CHK(min_gap >= GAP, 1'b1)
		`CHK(n_refuse > 0, 1'b1)
		wrap_up;
	end
endmodule // tb_top
